// [src/lcd_dio_mux_clock_config.sv]
// Configuration bank for LCD/digital I/O pin sharing, segment data, processor clock and input mux
//
// How it works
// - The pin-sharing count gives segment pins to the LCD from pin 41 downward, 18 meaning pins 24-41.
// - Each added segment pin takes away the highest digital I/O pin, so 9 gives segments 33-41, I/O 4-12.
// - Every segment word holds display state for up to four common periods.
// - Bit 0 of a segment word drives the first common period and bit 3 the fourth.
// - Divider code d makes the processor clock the compute-engine clock divided by two to the d.
// - The divider resets to zero so the processor starts on the undivided clock.
// - Software may rewrite the divider while running from the divided clock without upsetting itself.
// - The alternate-select bit steers conversions to the alternate input set.
// - The two-bit state count picks 6, 4, 3 or 2 multiplexer states per cycle.
// - With sync enable high, segment pin 7 carries the input_out_a signal instead of segment data.
`timescale 1ns/10ps
`default_nettype none

module lcd_dio_mux_clock_config
  import lcd_dio_cfg_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic [DATA_W-1:0]     reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [DATA_W-1:0]          reg_rdata,
  input  wire logic [1:0]            common_phase,
  input  wire logic                  input_out_a,
  output logic [SEG_COUNT-1:0]       segment_pin_level,
  output logic [SEG_COUNT-1:0]       segment_pin_is_lcd,
  output logic [DIO_COUNT-1:0]       digital_io_pin_enable,
  output logic                       segment_pin_seven_is_sync,
  output logic                       processor_clock_tick,
  output logic [DIV_W-1:0]           processor_clock_divider_active,
  output logic                       input_mux_alternate_select,
  output logic [2:0]                 input_mux_states_per_cycle
);

  // Registered state and next values
  reg_req_t                req;
  logic [3:0]              seg_word_ff [SEG_COUNT];
  logic [3:0]              nxt_seg_word [SEG_COUNT];
  logic [DIV_W-1:0]        clk_div_ff;
  logic [DIV_W-1:0]        nxt_clk_div;
  logic [DIV_W-1:0]        div_active_ff;
  logic [DIV_W-1:0]        nxt_div_active;
  logic [DIV_CNT_W-1:0]    div_cnt_ff;
  logic [DIV_CNT_W-1:0]    nxt_div_cnt;
  logic [DIV_CNT_W-1:0]    div_last;
  mux_cfg_t                mux_ff;
  mux_cfg_t                nxt_mux;
  logic [SHARE_W-1:0]      share_ff;
  logic [SHARE_W-1:0]      nxt_share;
  logic [SHARE_W-1:0]      share_eff;
  logic [DATA_W-1:0]       rdata_ff;
  logic [DATA_W-1:0]       nxt_rdata;
  logic [SEG_COUNT-1:0]    seg_level_ff;
  logic [SEG_COUNT-1:0]    nxt_seg_level;
  logic [SEG_COUNT-1:0]    seg_lcd_ff;
  logic [SEG_COUNT-1:0]    nxt_seg_lcd;
  logic [DIO_COUNT-1:0]    dio_en_ff;
  logic [DIO_COUNT-1:0]    nxt_dio_en;
  logic [2:0]              mux_states_ff;
  logic [2:0]              nxt_mux_states;
  logic                    seg_hit;
  logic [ADDR_W-1:0]       seg_offset;
  logic [SEG_IDX_W-1:0]    seg_idx;

  // Bus request gathered into one carrier
  assign req.addr  = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr    = reg_wr;
  assign req.rd    = reg_rd;

  // Segment words sit at consecutive bytes from the segment base
  assign seg_offset = req.addr - SEG_BASE_ADDR;
  assign seg_hit    = (req.addr >= SEG_BASE_ADDR) && (seg_offset < ADDR_W'(SEG_COUNT));
  assign seg_idx    = seg_offset[SEG_IDX_W-1:0];

  // Segment data words, one per segment pin
  generate
    for (genvar i = 0; i < SEG_COUNT; i++)
    begin : g_seg
      always_comb
      begin
        nxt_seg_word[i] = seg_word_ff[i];
        if (req.wr && seg_hit && (seg_idx == SEG_IDX_W'(i)))
        begin
          nxt_seg_word[i] = req.wdata[3:0];
        end
      end

      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
          seg_word_ff[i] <= SEG_WORD_RESET;
        else
          seg_word_ff[i] <= nxt_seg_word[i];
      end

      // Common period n is bit n; pin 7 may carry the input_out_a instead
      always_comb
      begin
        nxt_seg_level[i] = seg_word_ff[i][common_phase];
        if ((i == SYNC_SEG) && mux_ff.input_input_out_a_output_enable)
        begin
          nxt_seg_level[i] = input_out_a;
        end
      end

      // Shared pins go to the LCD from pin 41 downward
      always_comb
      begin
        if (i < SHARED_BASE)
          nxt_seg_lcd[i] = 1'b1;
        else
          nxt_seg_lcd[i] = (SHARE_W'(i - SHARED_BASE) >= (SHARE_W'(SHARED_COUNT) - share_eff));
      end
    end

    // Digital I/O pins 0-3 are never shared; each added segment drops the top one
    for (genvar j = 0; j < DIO_COUNT; j++)
    begin : g_dio
      always_comb
      begin
        if (j < DIO_FIXED)
          nxt_dio_en[j] = 1'b1;
        else
          nxt_dio_en[j] = (SHARE_W'(j) < (SHARE_W'(DIO_COUNT) - share_eff));
      end
    end
  endgenerate

  // Counts above the number of shared pins behave as all pins given to the LCD
  assign share_eff = (share_ff > PIN_SHARE_MAX) ? PIN_SHARE_MAX : share_ff;

  // Configuration writes
  always_comb
  begin
    nxt_clk_div = clk_div_ff;
    nxt_mux     = mux_ff;
    nxt_share   = share_ff;
    if (req.wr)
    begin
      if (req.addr == MUX_COUNT_ADDR)
        nxt_mux.input_mux_state_count = req.wdata[MUX_COUNT_LSB +: 2];
      else if (req.addr == CLK_DIV_ADDR)
        nxt_clk_div = req.wdata[DIV_W-1:0];
      else if (req.addr == MUX_CTRL_ADDR)
      begin
        nxt_mux.input_mux_alternate_select   = req.wdata[INPUT_MUX_ALTERNATE_SELECT_BIT];
        nxt_mux.input_input_out_a_output_enable = req.wdata[INPUT_OUT_A_BIT];
      end
      else if (req.addr == PIN_SHARE_ADDR)
        nxt_share = req.wdata[SHARE_W-1:0];
    end
  end

  // Read data appears in the cycle after the read strobe; unmapped reads give zero
  always_comb
  begin
    nxt_rdata = '0;
    if (req.rd)
    begin
      if (req.addr == MUX_COUNT_ADDR)
        nxt_rdata[MUX_COUNT_LSB +: 2] = mux_ff.input_mux_state_count;
      else if (req.addr == CLK_DIV_ADDR)
        nxt_rdata[DIV_W-1:0] = clk_div_ff;
      else if (req.addr == MUX_CTRL_ADDR)
      begin
        nxt_rdata[INPUT_MUX_ALTERNATE_SELECT_BIT]  = mux_ff.input_mux_alternate_select;
        nxt_rdata[INPUT_OUT_A_BIT] = mux_ff.input_input_out_a_output_enable;
      end
      else if (req.addr == PIN_SHARE_ADDR)
        nxt_rdata[SHARE_W-1:0] = share_ff;
      else if (seg_hit)
        nxt_rdata[3:0] = seg_word_ff[seg_idx];
    end
  end

  // States per cycle for the input multiplexer
  always_comb
  begin
    case (mux_ff.input_mux_state_count)
      2'b00:   nxt_mux_states = MUX_STATES_00;
      2'b01:   nxt_mux_states = MUX_STATES_01;
      2'b10:   nxt_mux_states = MUX_STATES_10;
      default: nxt_mux_states = MUX_STATES_11;
    endcase
  end

  // Processor clock divider: tick once every 2^d compute-engine cycles
  assign div_last = DIV_CNT_W'((8'h01 << div_active_ff) - 8'h01);

  always_comb
  begin
    nxt_div_cnt    = div_cnt_ff + 7'h01;
    nxt_div_active = div_active_ff;
    // A new code is taken only where the old period ends
    if (div_cnt_ff == div_last)
    begin
      nxt_div_cnt    = 7'h00;
      nxt_div_active = clk_div_ff;
    end
  end

  // Tick marks the last compute-engine cycle of a processor clock period
  assign processor_clock_tick = (div_cnt_ff == div_last);

  // Configuration registers
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      clk_div_ff <= CLK_DIV_RESET;
      mux_ff     <= '{1'b0, 1'b0, MUX_COUNT_RESET};
      share_ff   <= PIN_SHARE_RESET;
    end
    else
    begin
      clk_div_ff <= nxt_clk_div;
      mux_ff     <= nxt_mux;
      share_ff   <= nxt_share;
    end
  end

  // Divider in use and its cycle counter restart together at a tick
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_active_ff <= CLK_DIV_RESET;
      div_cnt_ff    <= 7'h00;
    end
    else
    begin
      div_active_ff <= nxt_div_active;
      div_cnt_ff    <= nxt_div_cnt;
    end
  end

  // Read data register, zero outside the cycle after a read
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_ff <= 8'h00;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Pin role and level registers
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      seg_level_ff <= '0;
      seg_lcd_ff   <= '0;
      dio_en_ff    <= '0;
    end
    else
    begin
      seg_level_ff <= nxt_seg_level;
      seg_lcd_ff   <= nxt_seg_lcd;
      dio_en_ff    <= nxt_dio_en;
    end
  end

  // Decoded multiplexer state count
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      mux_states_ff <= MUX_STATES_00;
    end
    else
    begin
      mux_states_ff <= nxt_mux_states;
    end
  end

  // Outputs straight from registers
  assign reg_rdata                      = rdata_ff;
  assign segment_pin_level              = seg_level_ff;
  assign segment_pin_is_lcd             = seg_lcd_ff;
  assign digital_io_pin_enable          = dio_en_ff;
  assign segment_pin_seven_is_sync      = mux_ff.input_input_out_a_output_enable;
  assign processor_clock_divider_active = div_active_ff;
  assign input_mux_alternate_select     = mux_ff.input_mux_alternate_select;
  assign input_mux_states_per_cycle     = mux_states_ff;

endmodule

`default_nettype wire

// [src/lcd_dio_cfg_pkg.sv]
// Constants and types for the LCD, digital I/O, clock divider and input mux configuration bank
package lcd_dio_cfg_pkg;

  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned SEG_COUNT     = 42;
  localparam int unsigned SEG_IDX_W     = 6;
  localparam int unsigned SHARED_COUNT  = 18;
  localparam int unsigned SHARED_BASE   = 24;
  localparam int unsigned DIO_COUNT     = 22;
  localparam int unsigned DIO_FIXED     = 4;
  localparam int unsigned COMMONS       = 4;
  localparam int unsigned SYNC_SEG      = 7;
  localparam int unsigned DIV_W         = 3;
  localparam int unsigned DIV_CNT_W     = 7;
  localparam int unsigned SHARE_W       = 5;

  // Register byte addresses
  localparam logic [15:0] MUX_COUNT_ADDR = 16'h2002;
  localparam logic [15:0] CLK_DIV_ADDR   = 16'h2004;
  localparam logic [15:0] MUX_CTRL_ADDR  = 16'h2005;
  localparam logic [15:0] PIN_SHARE_ADDR = 16'h2040;
  localparam logic [15:0] SEG_BASE_ADDR  = 16'h2100;

  // Field positions
  localparam int unsigned MUX_COUNT_LSB  = 6;
  localparam int unsigned INPUT_OUT_A_BIT   = 0;
  localparam int unsigned INPUT_MUX_ALTERNATE_SELECT_BIT    = 2;

  // Reset values and the largest effective pin-share count
  localparam logic [2:0] CLK_DIV_RESET   = 3'h0;
  localparam logic [1:0] MUX_COUNT_RESET = 2'h0;
  localparam logic [4:0] PIN_SHARE_RESET = 5'h00;
  localparam logic [3:0] SEG_WORD_RESET  = 4'h0;
  localparam logic [4:0] PIN_SHARE_MAX   = 5'h12;

  // Multiplexer states per cycle for each state count code
  localparam logic [2:0] MUX_STATES_00 = 3'h6;
  localparam logic [2:0] MUX_STATES_01 = 3'h4;
  localparam logic [2:0] MUX_STATES_10 = 3'h3;
  localparam logic [2:0] MUX_STATES_11 = 3'h2;

  typedef struct packed {
    logic       input_mux_alternate_select;
    logic       input_input_out_a_output_enable;
    logic [1:0] input_mux_state_count;
  } mux_cfg_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

// [tb/cfg_bank_checker.sv]
// Port-level assertions for the configuration bank
`timescale 1ns/10ps
`default_nettype none
module cfg_bank_checker
  import lcd_dio_cfg_pkg::*;
(
  input wire logic                 mclk,
  input wire logic                 resetn,
  input wire logic                 reg_rd,
  input wire logic [DATA_W-1:0]    reg_rdata,
  input wire logic                 input_out_a,
  input wire logic [SEG_COUNT-1:0] segment_pin_level,
  input wire logic [SEG_COUNT-1:0] segment_pin_is_lcd,
  input wire logic [DIO_COUNT-1:0] digital_io_pin_enable,
  input wire logic                 segment_pin_seven_is_sync,
  input wire logic                 processor_clock_tick,
  input wire logic [DIV_W-1:0]     processor_clock_divider_active,
  input wire logic [2:0]           input_mux_states_per_cycle
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  sequence s_tick_d2;
    processor_clock_tick ##1 processor_clock_divider_active == 3'h2;
  endsequence
  sequence s_sync_on;
    segment_pin_seven_is_sync ##1 segment_pin_seven_is_sync;
  endsequence
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_SYNC_LEVEL: assert property (
    s_sync_on |-> segment_pin_level[7] == $past(input_out_a))
    else $error("segment pin seven does not follow sync");
  AST_FIXED_PINS: assert property (
    $past(resetn) |-> &digital_io_pin_enable[3:0] && &segment_pin_is_lcd[23:0])
    else $error("fixed pins lost their role");
  AST_PIN_SPLIT: assert property ($past(resetn) |->
    $countones(segment_pin_is_lcd[41:24]) + $countones(digital_io_pin_enable[21:4]) == 18)
    else $error("shared pins not split between segment and io");
  AST_TOP_DOWN: assert property (
    (segment_pin_is_lcd[40:24] & ~segment_pin_is_lcd[41:25]) == 17'h0_0000)
    else $error("segment pins not given from the top");
  AST_TICK_D0: assert property (processor_clock_divider_active == 3'h0 |-> processor_clock_tick)
    else $error("undivided clock missing a tick");
  AST_TICK_D2: assert property (
    s_tick_d2 |-> !processor_clock_tick [*3] ##1 processor_clock_tick)
    else $error("divide by four period wrong");
  AST_DIV_AT_TICK: assert property (
    !processor_clock_tick |=> $stable(processor_clock_divider_active))
    else $error("divider changed mid period");
  AST_STATES_LEGAL: assert property (
    input_mux_states_per_cycle inside {3'h6, 3'h4, 3'h3, 3'h2})
    else $error("illegal mux state count");
endmodule
bind lcd_dio_mux_clock_config cfg_bank_checker u_cfg_bank_checker (.*);
`default_nettype wire

// [tb/tb_lcd_dio_mux_clock_config.sv]
// Self-checking bench for the configuration bank
`timescale 1ns/10ps
`default_nettype none
module tb_lcd_dio_mux_clock_config
  import lcd_dio_cfg_pkg::*;
;
  logic        mclk, resetn, reg_wr, reg_rd, input_out_a, processor_clock_tick;
  logic        segment_pin_seven_is_sync, input_mux_alternate_select;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [1:0]  common_phase;
  logic [41:0] segment_pin_level, segment_pin_is_lcd, exp_v;
  logic [21:0] digital_io_pin_enable;
  logic [2:0]  processor_clock_divider_active, input_mux_states_per_cycle;
  int          errors, checks_done, cyc, seed, cnt, seg_m[42];
  int          nv[6] = '{0, 1, 9, 17, 18, 25};
  lcd_dio_mux_clock_config u_lcd_dio_mux_clock_config (.*);
  task automatic chk(input string nm, input logic [41:0] e, input logic [41:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk("reg_rdata", {34'h0, e}, {34'h0, reg_rdata});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      test_done;
    end
  end
  initial
  begin
    seed = 32'h24c1;
    {resetn, reg_wr, reg_rd, input_out_a, common_phase, reg_addr, reg_wdata} = '0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    chk("tick", 1, processor_clock_tick);
    chk("states", 6, input_mux_states_per_cycle);
    rd(CLK_DIV_ADDR, 8'h00);
    rd(MUX_CTRL_ADDR, 8'h00);
    $display("reset test done");
    foreach (nv[i])
    begin
      wr(PIN_SHARE_ADDR, 8'(nv[i]));
      for (int k = 0; k < 42; k++)
        exp_v[k] = k < 24 || k - 24 >= 18 - (nv[i] > 18 ? 18 : nv[i]);
      chk("is_lcd", exp_v, segment_pin_is_lcd);
      for (int k = 0; k < 42; k++)
        exp_v[k] = k < 22 - (nv[i] > 18 ? 18 : nv[i]);
      chk("dio_en", exp_v, {20'h0, digital_io_pin_enable});
      rd(PIN_SHARE_ADDR, 8'(nv[i]));
    end
    $display("pin share test done");
    for (int i = 0; i < 42; i++)
    begin
      seg_m[i] = $random(seed);
      wr(SEG_BASE_ADDR + 16'(i), 8'(seg_m[i]));
      rd(SEG_BASE_ADDR + 16'(i), 8'(seg_m[i]) & 8'h0f);
    end
    for (int p = 0; p < 4; p++)
    begin
      @(posedge mclk);
      common_phase <= 2'(p);
      repeat (2) @(negedge mclk);
      for (int i = 0; i < 42; i++)
        exp_v[i] = seg_m[i][p];
      chk("seg_level", exp_v, segment_pin_level);
    end
    $display("segment test done");
    for (int c = 0; c < 4; c++)
    begin
      wr(MUX_COUNT_ADDR, 8'(c << 6));
      chk("states", c == 0 ? 6 : c == 1 ? 4 : c == 2 ? 3 : 2, input_mux_states_per_cycle);
      rd(MUX_COUNT_ADDR, 8'(c << 6));
    end
    wr(MUX_CTRL_ADDR, 8'h05);
    chk("segment_pin_seven_sync", 1, segment_pin_seven_is_sync);
    for (int v = 0; v < 2; v++)
    begin
      @(posedge mclk);
      input_out_a <= v[0];
      repeat (2) @(negedge mclk);
      chk("sync_level", v, segment_pin_level[7]);
    end
    chk("alt_sel", 1, input_mux_alternate_select);
    rd(MUX_CTRL_ADDR, 8'h05);
    wr(MUX_CTRL_ADDR, 8'h00);
    chk("segment_pin_seven_sync", 0, segment_pin_seven_is_sync);
    chk("alt_sel", 0, input_mux_alternate_select);
    chk("segment_pin_seven_level", seg_m[7][3], segment_pin_level[7]);
    wr(16'h2003, 8'hff);
    rd(16'h2003, 8'h00);
    $display("mux test done");
    for (int d = 0; d < 8; d++)
    begin
      wr(CLK_DIV_ADDR, 8'(d));
      while (processor_clock_divider_active !== 3'(d) || processor_clock_tick !== 1'b1)
        @(negedge mclk);
      cnt = 0;
      do
      begin
        @(negedge mclk);
        cnt++;
      end while (processor_clock_tick !== 1'b1);
      chk("tick_period", 1 << d, cnt);
    end
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(negedge mclk);
    chk("div_active", 0, processor_clock_divider_active);
    chk("tick", 1, processor_clock_tick);
    rd(CLK_DIV_ADDR, 8'h00);
    rd(MUX_COUNT_ADDR, 8'h00);
    rd(PIN_SHARE_ADDR, 8'h00);
    rd(SEG_BASE_ADDR + 16'h0005, 8'h00);
    $display("divider test done");
    test_done;
  end
endmodule
`default_nettype wire
